/* File: design/ibec_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef IBEC_CONSTS_SVH
`define IBEC_CONSTS_SVH
// ==========================================
// register offsets (word index = byte address here)
`define IBEC_OFF_CTRL 4'h0
`define IBEC_OFF_STAT 4'h1
`define IBEC_OFF_FLAG 4'h2
`define IBEC_OFF_CLKSEL 4'h3
`define IBEC_OFF_CLKEXT 4'h4
`define IBEC_OFF_DATA 4'h5
`define IBEC_OFF_IRQ_STAT 4'h6
`define IBEC_OFF_IRQ_MASK 4'h7
// ==========================================
// control register fields
`define IBEC_CTRL_EN 7
`define IBEC_CTRL_EXIT 6
`define IBEC_CTRL_SPIE 4
`define IBEC_CTRL_STT 1
`define IBEC_CTRL_SPT 0
// status register fields
`define IBEC_STAT_MSTS 7
`define IBEC_STAT_SDET 1
`define IBEC_STAT_PDET 0
// flag register fields
`define IBEC_FLAG_PERMIT 1
`define IBEC_FLAG_BUSY 6
// irq status bits
`define IBEC_IRQ_STOP 0
`define IBEC_IRQ_XFER 1
`define IBEC_IRQ_START 2
// ==========================================
// reset values
`define IBEC_RST_CTRL 8'h00
`define IBEC_RST_MASK 8'h00
// ==========================================
// timing
`define IBEC_CLK_NS 40
`define IBEC_HALF_NS 5000
`define IBEC_HALF_CYC (`IBEC_HALF_NS / `IBEC_CLK_NS)
`define IBEC_ACK_BITS 8
`endif

/* File: design/ibec_pkg.sv */
// types shared by the bus enable and start control block
package ibec_pkg;
  // ==========================================
  // master sequencer states, gray coded in the order listed
  typedef enum logic [2:0] {
    IBEC_IDLE = 3'b000,
    IBEC_START = 3'b001,
    IBEC_SHIFT = 3'b011,
    IBEC_WAIT = 3'b010,
    IBEC_STOP = 3'b110
  } ibec_state_e;
endpackage

/* File: design/ibec_sync.sv */
// two flip-flop synchroniser for one bus pin
`timescale 1ns/1ps
module ibec_sync (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic pin_sync
);
  // first stage, read only by the second stage
  logic meta_q;
  // ==========================================
  // double register; bus idles high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      meta_q <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule // ibec_sync

/* File: design/ibec_top.sv */
// i2c bus enable, busy flag and start/stop trigger control
// Summary of operation
// [R1] permit 0: busy set at enable
// [R2] software frees bus with stop first
// [R3] no master start before stop seen
// [R4] program clock select, then enable
// [R5] permit 1: busy cleared at enable
// [R6] software checks bus free first
// [R7] enable with sda low, scl high: start
// [R8] extension code after start gets ack
// [R9] safe join: spie off, enable, exit
// [R10] exit bit abandons detection, no ack
// [R11] stop interrupt enable gates stop irq
// [R12] clock fields changed only while disabled
// [R13] no retrigger before hardware clears
// [R14] reserve: software sets stop irq enable
// [R15] reserved transfer starts on data write
// [R16] no stop irq: stays halted waiting
// [R17] software may poll master flag instead
// [R18] data register touched only in wait
// [R19] hardware clears start/stop triggers
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "ibec_consts.svh"
module ibec_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic i2c_event_irq
);
  // ==========================================
  // synchronised bus lines
  logic scl_s;
  logic sda_s;
  ibec_sync u_scl (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(scl_in),
    .pin_sync(scl_s)
  );
  ibec_sync u_sda (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(sda_in),
    .pin_sync(sda_s)
  );

  // ==========================================
  // registers
  logic [7:0] ctrl_q; // control register
  logic start_without_stop_permit_q; // flag register permit bit
  logic bus_busy_flag_q; // busy flag
  logic [7:0] clksel_q; // clock selection register
  logic clkext_q; // clock extension bit
  logic [7:0] data_q; // shift data register
  logic [2:0] irq_stat_q; // sticky events
  logic [2:0] irq_mask_q; // event mask
  logic master_state_flag_q; // master status
  logic stop_det_q; // stop detected since enable; set at enable when permit is 1
  logic start_det_q; // start detected
  logic scl_d1_q; // previous synced scl
  logic sda_d1_q; // previous synced sda
  logic en_d1_q; // previous enable
  ibec_pkg::ibec_state_e state_q; // master sequencer
  logic [7:0] cnt_q; // half-period counter
  logic [3:0] bit_q; // bit counter
  logic phase_q; // scl phase within a bit
  logic [7:0] sh_q; // slave receive shifter
  logic [3:0] rxbit_q; // slave bit count
  logic ack_q; // slave ack drive request
  logic reserve_q; // transmission reserved

  // register decode helper, used by both strobes
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  logic enable;
  logic en_rise;
  logic bus_start;
  logic bus_stop;
  logic data_wr;
  logic step;
  assign enable = ctrl_q[`IBEC_CTRL_EN];
  assign en_rise = enable && !en_d1_q;
  // start: sda falls while scl high; also enable with sda low, scl high
  assign bus_start = (sda_d1_q && !sda_s && scl_s) ||
                     (en_rise && !sda_s && scl_s); // [R7]
  assign bus_stop = !sda_d1_q && sda_s && scl_s;
  assign data_wr = reg_wr && hit(reg_addr, `IBEC_OFF_DATA);
  assign step = (cnt_q == 8'(`IBEC_HALF_CYC - 1));

  // ==========================================
  // line history for edge detection
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      en_d1_q <= 1'b0;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
      en_d1_q <= enable;
    end
  end

  // ==========================================
  // control register; triggers self-clear when their condition is sent
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `IBEC_RST_CTRL;
    end else begin
      if (reg_wr && hit(reg_addr, `IBEC_OFF_CTRL)) begin
        ctrl_q <= reg_wdata;
      end else begin
        // exit bit is a one-shot action
        ctrl_q[`IBEC_CTRL_EXIT] <= 1'b0;
        if (state_q == ibec_pkg::IBEC_START && step && phase_q) begin
          ctrl_q[`IBEC_CTRL_STT] <= 1'b0; // [R19]
        end
        if (state_q == ibec_pkg::IBEC_STOP && step && phase_q) begin
          ctrl_q[`IBEC_CTRL_SPT] <= 1'b0; // [R19]
        end
        if (!enable) begin
          ctrl_q[`IBEC_CTRL_STT] <= 1'b0;
          ctrl_q[`IBEC_CTRL_SPT] <= 1'b0;
        end
      end
    end
  end

  // ==========================================
  // clock selection, extension and permit; plain storage
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clksel_q <= 8'h00;
      clkext_q <= 1'b0;
      start_without_stop_permit_q <= 1'b0;
    end else begin
      if (reg_wr && hit(reg_addr, `IBEC_OFF_CLKSEL)) begin
        clksel_q <= reg_wdata;
      end
      if (reg_wr && hit(reg_addr, `IBEC_OFF_CLKEXT)) begin
        clkext_q <= reg_wdata[0];
      end
      if (reg_wr && hit(reg_addr, `IBEC_OFF_FLAG)) begin
        start_without_stop_permit_q <= reg_wdata[`IBEC_FLAG_PERMIT];
      end
    end
  end

  // ==========================================
  // busy flag and stop-seen tracking
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_busy_flag_q <= 1'b0;
      stop_det_q <= 1'b0;
    end else if (!enable) begin
      bus_busy_flag_q <= 1'b0;
      stop_det_q <= 1'b0;
    end else if (en_rise) begin
      bus_busy_flag_q <= !start_without_stop_permit_q; // [R1] [R5]
      stop_det_q <= start_without_stop_permit_q;
    end else if (bus_stop) begin
      bus_busy_flag_q <= 1'b0;
      stop_det_q <= 1'b1;
    end else if (bus_start) begin
      bus_busy_flag_q <= 1'b1;
    end
  end

  // ==========================================
  // slave-side detection: after a start, collect first byte and ack
  // an extension code; the exit bit abandons it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_det_q <= 1'b0;
      sh_q <= 8'h00;
      rxbit_q <= 4'h0;
      ack_q <= 1'b0;
    end else if (!enable || ctrl_q[`IBEC_CTRL_EXIT] || bus_stop) begin
      start_det_q <= 1'b0; // [R10]
      rxbit_q <= 4'h0;
      ack_q <= 1'b0;
    end else if (bus_start && state_q == ibec_pkg::IBEC_IDLE) begin
      start_det_q <= 1'b1;
      rxbit_q <= 4'h0;
      ack_q <= 1'b0;
    end else if (start_det_q) begin
      if (scl_s && !scl_d1_q && rxbit_q < 4'(`IBEC_ACK_BITS)) begin
        sh_q <= {sh_q[6:0], sda_s};
        rxbit_q <= rxbit_q + 4'h1;
      end
      if (!scl_s && scl_d1_q && rxbit_q == 4'(`IBEC_ACK_BITS)) begin
        ack_q <= (sh_q[7:4] == 4'h0); // [R8]
        rxbit_q <= rxbit_q + 4'h1;
      end else if (!scl_s && scl_d1_q && ack_q) begin
        ack_q <= 1'b0;
        start_det_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // master sequencer: start, wait, shift, back to wait, stop
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ibec_pkg::IBEC_IDLE;
      cnt_q <= 8'h00;
      bit_q <= 4'h0;
      phase_q <= 1'b0;
      master_state_flag_q <= 1'b0;
      reserve_q <= 1'b0;
    end else if (!enable) begin
      state_q <= ibec_pkg::IBEC_IDLE;
      cnt_q <= 8'h00;
      phase_q <= 1'b0;
      master_state_flag_q <= 1'b0;
      reserve_q <= 1'b0;
    end else begin
      cnt_q <= step ? 8'h00 : cnt_q + 8'h01;
      unique case (state_q)
        ibec_pkg::IBEC_IDLE: begin
          phase_q <= 1'b0;
          // once reserved, the trigger waits for the data write path only
          if (ctrl_q[`IBEC_CTRL_STT] && !reserve_q) begin
            if (stop_det_q && !bus_busy_flag_q) begin // [R3]
              state_q <= ibec_pkg::IBEC_START;
              cnt_q <= 8'h00;
            end else begin
              reserve_q <= 1'b1; // wait for a stop
            end
          end else if (ctrl_q[`IBEC_CTRL_SPT]) begin
            state_q <= ibec_pkg::IBEC_STOP;
            cnt_q <= 8'h00;
          end
          // reserved: begin only on a data write after stop was flagged
          if (reserve_q && irq_stat_q[`IBEC_IRQ_STOP] && data_wr) begin
            state_q <= ibec_pkg::IBEC_START; // [R15] [R16]
            reserve_q <= 1'b0;
            cnt_q <= 8'h00;
          end
        end
        ibec_pkg::IBEC_START: begin
          if (step) begin
            phase_q <= !phase_q;
            if (phase_q) begin
              master_state_flag_q <= 1'b1;
              state_q <= ibec_pkg::IBEC_WAIT;
              bit_q <= 4'h0;
            end
          end
        end
        ibec_pkg::IBEC_WAIT: begin
          // halted with scl low until data or stop is written [R16]
          phase_q <= 1'b0;
          if (data_wr) begin
            state_q <= ibec_pkg::IBEC_SHIFT;
            bit_q <= 4'h0;
            cnt_q <= 8'h00;
          end else if (ctrl_q[`IBEC_CTRL_SPT]) begin
            state_q <= ibec_pkg::IBEC_STOP;
            cnt_q <= 8'h00;
          end
        end
        ibec_pkg::IBEC_SHIFT: begin
          if (step) begin
            phase_q <= !phase_q;
            if (phase_q) begin
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'(`IBEC_ACK_BITS)) begin
                state_q <= ibec_pkg::IBEC_WAIT;
              end
            end
          end
        end
        ibec_pkg::IBEC_STOP: begin
          if (step) begin
            phase_q <= !phase_q;
            if (phase_q) begin
              master_state_flag_q <= 1'b0;
              state_q <= ibec_pkg::IBEC_IDLE;
            end
          end
        end
        default: begin
          state_q <= ibec_pkg::IBEC_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // shift data register; shifts out msb first during transfer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= 8'h00;
    end else if (data_wr) begin
      data_q <= reg_wdata;
    end else if (state_q == ibec_pkg::IBEC_SHIFT && step && phase_q &&
                 bit_q < 4'(`IBEC_ACK_BITS)) begin
      data_q <= {data_q[6:0], sda_s};
    end
  end

  // ==========================================
  // pin drivers, open drain: drive low only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      unique case (state_q)
        ibec_pkg::IBEC_START: begin
          sda_oe <= 1'b1;
          scl_oe <= phase_q;
        end
        ibec_pkg::IBEC_WAIT: begin
          sda_oe <= 1'b0;
          scl_oe <= 1'b1;
        end
        ibec_pkg::IBEC_SHIFT: begin
          scl_oe <= !phase_q;
          sda_oe <= (bit_q < 4'(`IBEC_ACK_BITS)) && !data_q[7];
        end
        ibec_pkg::IBEC_STOP: begin
          // sda low under a low clock, then free the clock; idle frees sda
          scl_oe <= !phase_q;
          sda_oe <= 1'b1;
        end
        default: begin
          scl_oe <= 1'b0;
          sda_oe <= ack_q; // slave ack only
        end
      endcase
    end
  end

  // ==========================================
  // interrupt status: sticky, set wins over read-clear
  logic [2:0] ev;
  assign ev[`IBEC_IRQ_STOP] = bus_stop && enable &&
                              ctrl_q[`IBEC_CTRL_SPIE]; // [R11]
  assign ev[`IBEC_IRQ_XFER] = state_q == ibec_pkg::IBEC_SHIFT && step &&
                              phase_q && bit_q == 4'(`IBEC_ACK_BITS);
  assign ev[`IBEC_IRQ_START] = bus_start && enable;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
    end else begin
      if (reg_rd && hit(reg_addr, `IBEC_OFF_IRQ_STAT)) begin
        irq_stat_q <= ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      if (reg_wr && hit(reg_addr, `IBEC_OFF_IRQ_MASK)) begin
        irq_mask_q <= reg_wdata[2:0];
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      i2c_event_irq <= 1'b0;
    end else begin
      i2c_event_irq <= |(irq_stat_q & irq_mask_q & ~ev) | |(ev & irq_mask_q);
    end
  end

  // ==========================================
  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `IBEC_OFF_CTRL: reg_rdata <= ctrl_q;
        `IBEC_OFF_STAT: reg_rdata <= {master_state_flag_q, 5'h00,
                                      start_det_q, stop_det_q};
        `IBEC_OFF_FLAG: reg_rdata <= {1'b0, bus_busy_flag_q, 4'h0,
                                      start_without_stop_permit_q, 1'b0};
        `IBEC_OFF_CLKSEL: reg_rdata <= clksel_q;
        `IBEC_OFF_CLKEXT: reg_rdata <= {7'h00, clkext_q};
        `IBEC_OFF_DATA: reg_rdata <= data_q;
        `IBEC_OFF_IRQ_STAT: reg_rdata <= {5'h00, irq_stat_q};
        `IBEC_OFF_IRQ_MASK: reg_rdata <= {5'h00, irq_mask_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // ibec_top

/* File: tb/ibec_bus_model.sv */
// another party on the open drain bus: master only, behavioural
`timescale 1ns/1ps
module ibec_bus_model (
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic scl_in,
  output logic sda_in
);
  // ==========================================
  // line levels, pull-ups win when all release
  localparam int HALF_NS = 2000; // step delay of this party; a send_byte bit takes three
  logic scl_rel = 1'b1; // clock released by this party
  logic sda_rel = 1'b1; // data released by this party
  assign scl_in = scl_rel & ~scl_oe;
  assign sda_in = sda_rel & ~sda_oe;
  // transfer already running: data low under a high clock
  task automatic hold_start();
    #7 sda_rel = 1'b0;
    #HALF_NS;
  endtask
  // eight bits msb first, then the ninth clock samples acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    #7 ack = 1'b0;
    for (int i = 0; i < 9; i++) begin
      scl_rel = 1'b0;
      #HALF_NS sda_rel = (i == 8) ? 1'b1 : b[3'(7 - i)];
      #HALF_NS scl_rel = 1'b1;
      #HALF_NS ack = ~sda_in;
    end
  endtask
  // stop: data rises while clock is high, bus free afterwards
  task automatic do_stop();
    #7 scl_rel = 1'b0;
    #HALF_NS sda_rel = 1'b0;
    #HALF_NS scl_rel = 1'b1;
    #HALF_NS sda_rel = 1'b1;
    #HALF_NS;
  endtask
endmodule // ibec_bus_model

/* File: tb/ibec_monitor.sv */
// checker for the bus enable and start control block, with its bind
`timescale 1ns/1ps
`include "ibec_consts.svh"
module ibec_monitor (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic i2c_event_irq
);
  // ==========================================
  // software view and bus history
  logic en_q; // enable as written
  logic spie_q; // stop irq enable as written
  logic perm_q; // start without stop permit as written
  logic [7:0] mask_q; // irq mask as written
  logic sda_d1_q; // data line one cycle ago
  logic stop_seen_q; // stop seen on the pins since enable
  logic exit_q; // exit written, not yet ended by a stop
  logic spie_any_q; // stop irq enable set since last status read
  logic wr_ctrl; // write to control
  logic en_wr; // enabling write
  logic pin_stop; // data rises while clock high
  assign wr_ctrl = reg_wr && reg_addr == `IBEC_OFF_CTRL;
  assign en_wr = wr_ctrl && reg_wdata[`IBEC_CTRL_EN] && !en_q;
  assign pin_stop = sda_in && !sda_d1_q && scl_in;
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // track register writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= 1'b0;
      spie_q <= 1'b0;
      perm_q <= 1'b0;
      mask_q <= 8'h00;
    end else if (reg_wr) begin
      if (wr_ctrl) begin
        en_q <= reg_wdata[`IBEC_CTRL_EN];
        spie_q <= reg_wdata[`IBEC_CTRL_SPIE];
      end
      if (reg_addr == `IBEC_OFF_FLAG) perm_q <= reg_wdata[`IBEC_FLAG_PERMIT];
      if (reg_addr == `IBEC_OFF_IRQ_MASK) mask_q <= reg_wdata;
    end
  end
  // track bus events and their history
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_d1_q <= 1'b1;
      stop_seen_q <= 1'b0;
      exit_q <= 1'b0;
      spie_any_q <= 1'b0;
    end else begin
      sda_d1_q <= sda_in;
      if (en_wr) stop_seen_q <= 1'b0;
      else if (pin_stop) stop_seen_q <= 1'b1;
      if (wr_ctrl && reg_wdata[`IBEC_CTRL_EXIT]) exit_q <= 1'b1;
      else if (pin_stop) exit_q <= 1'b0;
      if (spie_q) spie_any_q <= 1'b1;
      else if (reg_rd && reg_addr == `IBEC_OFF_IRQ_STAT) spie_any_q <= 1'b0;
    end
  end
  // ==========================================
  // named steps
  sequence rd_s(logic [3:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence join_en_s;
    en_wr && !sda_in && scl_in;
  endsequence
  // ==========================================
  // assertions
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside the answer cycle");
  pins_low_a: assert property (!scl_out && !sda_out)
    else $error("open drain level not low");
  busy_enable_a: assert property (
    en_wr ##[1:4] rd_s(`IBEC_OFF_FLAG) |=> reg_rdata[6] == !perm_q)
    else $error("busy flag wrong after enable");
  start_seen_a: assert property (
    join_en_s ##[2:20] rd_s(`IBEC_OFF_STAT) |=> reg_rdata[1])
    else $error("start not seen on joining a busy bus");
  no_master_a: assert property (
    en_q && !perm_q && !stop_seen_q |-> !($rose(sda_oe) && scl_in))
    else $error("master start before any stop");
  exit_quiet_a: assert property (exit_q |-> !sda_oe)
    else $error("data driven after exit");
  stop_gate_a: assert property (
    !spie_any_q && !spie_q ##0 rd_s(`IBEC_OFF_IRQ_STAT) |=> !reg_rdata[0])
    else $error("stop status set with stop irq off");
  irq_masked_a: assert property (
    mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> !i2c_event_irq)
    else $error("irq raised while all masked");
endmodule // ibec_monitor
bind ibec_top ibec_monitor u_monitor (.core_clk, .rst_b, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_in, .scl_out, .scl_oe,
  .sda_in, .sda_out, .sda_oe, .i2c_event_irq);

/* File: tb/ibec_top_bench.sv */
// self-checking bench for the bus enable and start control block
`timescale 1ns/1ps
`include "ibec_consts.svh"
module ibec_top_bench;
  // ==========================================
  // signals and counters
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, i2c_event_irq;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  ibec_top DUT (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
    .i2c_event_irq);
  ibec_bus_model bus (.scl_oe, .sda_oe, .scl_in, .sda_in);
  // ==========================================
  // verdict, compares and bus cycles
  task automatic complete_run();
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t reg %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t level %b not %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rdbit(input logic [3:0] a, input int b, input logic e);
    logic [7:0] v;
    rd(a, v);
    chk1(v[b], e);
  endtask
  // watch n cycles for data being pulled low
  task automatic wait_oe(input int n, output logic seen);
    seen = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      #1 if (sda_oe === 1'b1) seen = 1'b1;
    end
  endtask
  // poll until the start trigger has dropped, bounded
  task automatic trig_clear();
    logic [7:0] v;
    rd(`IBEC_OFF_CTRL, v);
    for (int i = 0; i < 300 && v[`IBEC_CTRL_STT] !== 1'b0; i++)
      rd(`IBEC_OFF_CTRL, v);
    chk1(v[`IBEC_CTRL_STT], 1'b0);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [7:0] v;
    rd(`IBEC_OFF_CTRL, v);
    chk8(v, `IBEC_RST_CTRL);
    rd(`IBEC_OFF_IRQ_MASK, v);
    chk8(v, `IBEC_RST_MASK);
    wr(4'hf, 8'hff);
    rd(4'hf, v);
    chk8(v, 8'h00);
    wr(`IBEC_OFF_CLKSEL, 8'h0b); // clock chosen before enable
    rd(`IBEC_OFF_CLKSEL, v);
    chk8(v, 8'h0b);
  endtask
  task automatic t_busy0();
    logic seen;
    wr(`IBEC_OFF_CTRL, 8'h10); // stop irq enable for reserving
    wr(`IBEC_OFF_CTRL, 8'h90);
    rdbit(`IBEC_OFF_FLAG, `IBEC_FLAG_BUSY, 1'b1);
    wr(`IBEC_OFF_CTRL, 8'h92);
    wait_oe(300, seen);
    chk1(seen, 1'b0);
    rdbit(`IBEC_OFF_STAT, `IBEC_STAT_MSTS, 1'b0);
    bus.do_stop();
    repeat (4) @(posedge core_clk);
    #1 chk1(i2c_event_irq, 1'b0);
    wr(`IBEC_OFF_IRQ_MASK, 8'h01);
    repeat (3) @(posedge core_clk);
    #1 chk1(i2c_event_irq, 1'b1);
    wr(`IBEC_OFF_DATA, 8'ha0); // one data write after the trigger
    wait_oe(400, seen);
    chk1(seen, 1'b1);
    trig_clear(); // trigger left alone till it drops
    rdbit(`IBEC_OFF_IRQ_STAT, `IBEC_IRQ_STOP, 1'b1);
    repeat (3) @(posedge core_clk);
    #1 chk1(i2c_event_irq, 1'b0);
    wr(`IBEC_OFF_IRQ_MASK, 8'h00);
    wr(`IBEC_OFF_CTRL, 8'h00);
  endtask
  task automatic t_busy1();
    logic seen;
    logic [7:0] v;
    wr(`IBEC_OFF_FLAG, 8'h02);
    wr(`IBEC_OFF_CTRL, 8'h80);
    rdbit(`IBEC_OFF_FLAG, `IBEC_FLAG_BUSY, 1'b0);
    wr(`IBEC_OFF_CTRL, 8'h82); // bus known idle here
    wait_oe(400, seen);
    chk1(seen, 1'b1);
    trig_clear();
    chk1(scl_oe, 1'b1);
    wr(`IBEC_OFF_DATA, 8'h5a); // written in the wait state
    repeat (2260) @(posedge core_clk);
    rdbit(`IBEC_OFF_IRQ_STAT, `IBEC_IRQ_XFER, 1'b1);
    rd(`IBEC_OFF_DATA, v);
    chk8(v, 8'h5a);
    wr(`IBEC_OFF_CTRL, 8'h81);
    repeat (260) @(posedge core_clk);
    rdbit(`IBEC_OFF_CTRL, `IBEC_CTRL_SPT, 1'b0);
    rdbit(`IBEC_OFF_STAT, `IBEC_STAT_MSTS, 1'b0);
    wr(`IBEC_OFF_CTRL, 8'h00);
    wr(`IBEC_OFF_FLAG, 8'h00);
  endtask
  task automatic t_join(input logic exit_on, input logic ack_exp);
    logic ack;
    bus.hold_start();
    wr(`IBEC_OFF_CTRL, 8'h00); // stop irq off before enable
    wr(`IBEC_OFF_CTRL, 8'h80);
    repeat (6) @(posedge core_clk);
    rdbit(`IBEC_OFF_STAT, `IBEC_STAT_SDET, 1'b1);
    if (exit_on) wr(`IBEC_OFF_CTRL, 8'hc0); // inside join window
    bus.send_byte(8'h00, ack);
    chk1(ack, ack_exp);
    bus.do_stop();
    wr(`IBEC_OFF_CTRL, 8'h00);
  endtask
  task automatic t_resv();
    logic seen;
    logic [7:0] v;
    rd(`IBEC_OFF_IRQ_STAT, v);
    wr(`IBEC_OFF_IRQ_MASK, 8'h01);
    wr(`IBEC_OFF_CTRL, 8'h80);
    wr(`IBEC_OFF_CTRL, 8'h82);
    bus.do_stop();
    rdbit(`IBEC_OFF_STAT, `IBEC_STAT_MSTS, 1'b0); // polled instead
    rdbit(`IBEC_OFF_IRQ_STAT, `IBEC_IRQ_STOP, 1'b0);
    chk1(i2c_event_irq, 1'b0);
    wr(`IBEC_OFF_DATA, 8'ha0);
    wait_oe(400, seen);
    chk1(seen, 1'b0);
    wr(`IBEC_OFF_CTRL, 8'h00);
    wr(`IBEC_OFF_IRQ_MASK, 8'h00);
  endtask
  // ==========================================
  // clock, hang limit and main sequence
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_busy0();
    t_busy1();
    t_join(1'b1, 1'b0);
    t_join(1'b0, 1'b1);
    t_resv();
    complete_run();
  end
endmodule // ibec_top_bench
